// File: core/sssc_pkg.sv
package sssc_pkg;
	// register locations on the mpu side
	localparam logic [7:0] SSSC_SFR_CMD = 8'hfd; // host_command_capture, sfr space
	localparam logic [15:0] SSSC_ADDR_STAT = 16'h2708; // serial_transaction_status
	localparam logic [15:0] SSSC_ADDR_CTRL = 16'h270c; // enable and write restrict
	localparam int SSSC_BIT_EN = 4; // serial_port_enable in SSSC_ADDR_CTRL
	localparam int SSSC_BIT_SAFE = 3; // serial_write_restrict in SSSC_ADDR_CTRL
	localparam logic SSSC_RST_EN = 1'h1;
	localparam logic SSSC_RST_SAFE = 1'h0;
	localparam logic [7:0] SSSC_RST_STAT = 8'h00;
	localparam logic [7:0] SSSC_RST_CMD = 8'h00;
	// status field positions
	localparam int SSSC_ST_RDY_ERR = 7;
	localparam int SSSC_ST_RPAR = 6;
	localparam int SSSC_ST_WPAR = 5;
	localparam int SSSC_ST_CNT_HI = 4;
	localparam int SSSC_ST_CNT_LO = 2;
	localparam int SSSC_ST_FLASH = 1;
	localparam int SSSC_ST_FLASH_RDY = 0;
	localparam logic [2:0] SSSC_CNT_NO_DATA = 3'h7; // count shown when no data bytes
	// command byte fields
	localparam int SSSC_CMD_READ = 7; // 1 = master reads, 0 = master writes
	localparam int SSSC_CMD_FLASH = 6; // 1 = flash space, 0 = data ram
	// window of data ram that stays writable under write restrict
	localparam int SSSC_SAFE_LEN = 16;
	localparam logic [7:0] SSSC_IDLE_BYTE = 8'h00;
	// transaction phase, gray along the usual path
	typedef enum logic [1:0] {
		SSSC_PH_CMD = 2'b00,
		SSSC_PH_AHI = 2'b01,
		SSSC_PH_ALO = 2'b11,
		SSSC_PH_DATA = 2'b10
	} sssc_phase_t;
endpackage : sssc_pkg

// File: core/sssc_shifter.sv
`timescale 1ns/10ps
// pin synchronisers and mode 0 byte shifter, msb first
module sssc_shifter import sssc_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sck_pin,
	input wire logic csn_pin,
	input wire logic mosi_pin,
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic frame_start,
	output logic frame_end,
	output logic frame_active,
	output logic miso
);
	logic sck_s1_ff, sck_s2_ff, sck_s3_ff, csn_s1_ff, csn_s2_ff, csn_s3_ff;
	logic mosi_s1_ff, mosi_s2_ff;
	logic [2:0] bit_cnt_ff, nxt_bit_cnt;
	logic [7:0] rx_sh_ff, nxt_rx_sh, tx_sh_ff, nxt_tx_sh, rx_byte_ff, nxt_rx_byte;
	logic pend_ff, nxt_pend, rx_valid_ff, nxt_rx_valid;
	logic sck_rise, sck_fall;

	// two flops per pin; the third stage only feeds edge detection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{sck_s1_ff, sck_s2_ff, sck_s3_ff} <= 3'h0;
			{csn_s1_ff, csn_s2_ff, csn_s3_ff} <= 3'h7;
			{mosi_s1_ff, mosi_s2_ff} <= 2'h0;
		end else begin
			sck_s1_ff <= sck_pin;
			sck_s2_ff <= sck_s1_ff;
			sck_s3_ff <= sck_s2_ff;
			csn_s1_ff <= csn_pin;
			csn_s2_ff <= csn_s1_ff;
			csn_s3_ff <= csn_s2_ff;
			mosi_s1_ff <= mosi_pin;
			mosi_s2_ff <= mosi_s1_ff;
		end
	end

	assign sck_rise = sck_s2_ff & ~sck_s3_ff;
	assign sck_fall = ~sck_s2_ff & sck_s3_ff;
	assign frame_start = ~csn_s2_ff & csn_s3_ff;
	assign frame_end = csn_s2_ff & ~csn_s3_ff;
	assign frame_active = ~csn_s2_ff;

	// sample on rising, shift out on falling; next byte loads on the falling
	// edge after a byte, giving the core half an sck period to prepare it
	always_comb begin
		nxt_bit_cnt = bit_cnt_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_rx_byte = rx_byte_ff;
		nxt_pend = pend_ff;
		nxt_rx_valid = 1'b0;
		if (frame_start) begin
			nxt_bit_cnt = 3'h0;
			nxt_tx_sh = tx_byte;
			nxt_pend = 1'b0;
		end else if (frame_active && sck_rise) begin
			nxt_rx_sh = {rx_sh_ff[6:0], mosi_s2_ff};
			nxt_bit_cnt = bit_cnt_ff + 3'h1;
			if (bit_cnt_ff == 3'h7) begin
				nxt_rx_byte = {rx_sh_ff[6:0], mosi_s2_ff};
				nxt_rx_valid = 1'b1;
				nxt_pend = 1'b1;
			end
		end else if (frame_active && sck_fall) begin
			nxt_tx_sh = pend_ff ? tx_byte : {tx_sh_ff[6:0], 1'b0};
			nxt_pend = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			tx_sh_ff <= 8'h00;
			rx_byte_ff <= 8'h00;
			pend_ff <= 1'b0;
			rx_valid_ff <= 1'b0;
		end else begin
			bit_cnt_ff <= nxt_bit_cnt;
			rx_sh_ff <= nxt_rx_sh;
			tx_sh_ff <= nxt_tx_sh;
			rx_byte_ff <= nxt_rx_byte;
			pend_ff <= nxt_pend;
			rx_valid_ff <= nxt_rx_valid;
		end
	end

	assign rx_byte = rx_byte_ff;
	assign rx_valid = rx_valid_ff;
	assign miso = tx_sh_ff[7];
endmodule : sssc_shifter

// File: core/sssc_top.sv
`timescale 1ns/10ps
// Overview of operation
// - enable bit routes port onto shared pins 36-39 if their segment map bits clear
// - write restrict passes only command capture and one 16-byte ram window
// - command byte from the master is captured into a read-only mpu register
// - status describes the last finished transaction, readable by master later
// - bit 7 flags that the memory was not ready for the requested access
// - bit 6 is parity of bytes returned, status byte excluded
// - bit 5 is parity of all bytes written, command and address included
// - bits 4..2 are low data byte count; no data bytes reports 111
// - bit 1 is flash mode, forced low while test pin is low
// - bit 0 shows flash ready for another write; master checks it first
// - flash read lock stops flash contents going out on reads
module sssc_top import sssc_pkg::*; #(
	parameter logic [15:0] SAFE_BASE = 16'h0000
) (
	input wire logic clock,
	input wire logic resetn,
	// spi pins
	input wire logic sck_pin,
	input wire logic csn_pin,
	input wire logic mosi_pin,
	output logic miso_out,
	output logic miso_oe,
	input wire logic test_pin,
	input wire logic [3:0] segment_pin_assign,
	output logic spi_pins_active,
	// mpu register port
	input wire logic mpu_sfr_sel,
	input wire logic [15:0] mpu_addr,
	input wire logic mpu_rd,
	input wire logic mpu_wr,
	input wire logic [7:0] mpu_wdata,
	output logic [7:0] mpu_rdata,
	// memory port
	output logic [15:0] mem_addr,
	output logic mem_flash,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ready,
	// flash state
	input wire logic flash_read_lock,
	input wire logic flash_mode,
	input wire logic flash_ready
);
	logic rst_s1_ff, rst_n_ff, test_s1_ff, test_s2_ff;
	logic en_ff, nxt_en, safe_ff, nxt_safe;
	logic [7:0] cmd_cap_ff, nxt_cmd_cap, stat_ff, nxt_stat, rdata_ff, nxt_rdata;
	sssc_phase_t phase_ff, nxt_phase;
	logic [7:0] cmd_ff, nxt_cmd, tx_ff, nxt_tx;
	logic [15:0] addr_ff, nxt_addr;
	logic [2:0] dcnt_ff, nxt_dcnt;
	logic seen_ff, nxt_seen, wpar_ff, nxt_wpar, rpar_ff, nxt_rpar;
	logic err_ff, nxt_err, rd_pend_ff, nxt_rd_pend, rd_go_ff, nxt_rd_go;
	logic [7:0] rx_byte, new_stat;
	logic rx_valid, frame_start, frame_end, frame_active, sh_miso;
	logic is_read, is_flash, in_safe, wr_ok, rd_ok, rd_now, wr_now;

	// reset asserts asynchronously, releases through two flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	// test pin arrives from outside the clock domain
	always_ff @(posedge clock or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			test_s1_ff <= 1'b0;
			test_s2_ff <= 1'b0;
		end else begin
			test_s1_ff <= test_pin;
			test_s2_ff <= test_s1_ff;
		end
	end

	// the port owns the pins only when no segment is mapped onto them
	assign spi_pins_active = en_ff & (segment_pin_assign == 4'h0);

	// a disabled port sees an idle bus, so no frame can start
	sssc_shifter u_shifter (
		.clock(clock),
		.rst_n(rst_n_ff),
		.sck_pin(sck_pin & spi_pins_active),
		.csn_pin(csn_pin | ~spi_pins_active),
		.mosi_pin(mosi_pin),
		.tx_byte(tx_ff),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid),
		.frame_start(frame_start),
		.frame_end(frame_end),
		.frame_active(frame_active),
		.miso(sh_miso)
	);
	assign miso_out = sh_miso;
	assign miso_oe = frame_active & spi_pins_active;

	// access decode for the data phase
	assign is_read = cmd_ff[SSSC_CMD_READ];
	assign is_flash = cmd_ff[SSSC_CMD_FLASH];
	assign in_safe = !is_flash && (addr_ff >= SAFE_BASE)
		&& ((addr_ff - SAFE_BASE) < 16'(SSSC_SAFE_LEN));
	assign wr_ok = !safe_ff || in_safe;
	assign rd_ok = !(is_flash && flash_read_lock);
	assign rd_now = rx_valid && is_read && rd_ok && mem_ready
		&& (phase_ff == SSSC_PH_ALO || phase_ff == SSSC_PH_DATA);
	assign wr_now = rx_valid && !is_read && wr_ok && mem_ready
		&& phase_ff == SSSC_PH_DATA;
	assign mem_rd = rd_go_ff; // one cycle late, so mem_addr already holds the new address
	assign mem_wr = wr_now;
	assign mem_addr = addr_ff;
	assign mem_flash = is_flash;
	assign mem_wdata = rx_byte;

	// status snapshot taken as the frame closes
	always_comb begin
		new_stat = SSSC_RST_STAT;
		new_stat[SSSC_ST_RDY_ERR] = err_ff;
		new_stat[SSSC_ST_RPAR] = rpar_ff;
		new_stat[SSSC_ST_WPAR] = wpar_ff;
		new_stat[SSSC_ST_CNT_HI:SSSC_ST_CNT_LO] = seen_ff ? dcnt_ff : SSSC_CNT_NO_DATA;
		new_stat[SSSC_ST_FLASH] = flash_mode & test_s2_ff;
		new_stat[SSSC_ST_FLASH_RDY] = flash_mode & test_s2_ff & flash_ready;
	end

	// transaction engine: phase, address, and the running status terms
	always_comb begin
		nxt_phase = phase_ff;
		nxt_cmd = cmd_ff;
		nxt_addr = addr_ff;
		nxt_tx = tx_ff;
		nxt_dcnt = dcnt_ff;
		nxt_seen = seen_ff;
		nxt_wpar = wpar_ff;
		nxt_rpar = rpar_ff;
		nxt_err = err_ff;
		nxt_rd_go = rd_now;
		nxt_rd_pend = rd_go_ff;
		nxt_stat = stat_ff;
		nxt_cmd_cap = cmd_cap_ff;
		if (rd_pend_ff) begin
			nxt_tx = mem_rdata;
		end
		if (frame_start) begin
			nxt_phase = SSSC_PH_CMD;
			nxt_dcnt = 3'h0;
			nxt_seen = 1'b0;
			nxt_wpar = 1'b0;
			nxt_rpar = 1'b0;
			nxt_err = 1'b0;
		end else if (frame_end) begin
			nxt_stat = new_stat;
			nxt_cmd_cap = cmd_ff;
			nxt_tx = new_stat; // first byte of the next frame
		end else if (rx_valid) begin
			nxt_wpar = wpar_ff ^ (^rx_byte);
			nxt_tx = SSSC_IDLE_BYTE;
			unique case (phase_ff)
				SSSC_PH_CMD: begin
					nxt_cmd = rx_byte;
					nxt_phase = SSSC_PH_AHI;
				end
				SSSC_PH_AHI: begin
					nxt_addr = {rx_byte, addr_ff[7:0]};
					nxt_phase = SSSC_PH_ALO;
				end
				SSSC_PH_ALO: begin
					nxt_addr = {addr_ff[15:8], rx_byte};
					nxt_phase = SSSC_PH_DATA;
					// the read for the first data byte is requested now; mem_rd follows a cycle later
					if (is_read && !mem_ready) begin
						nxt_err = 1'b1;
					end
				end
				SSSC_PH_DATA: begin
					nxt_dcnt = dcnt_ff + 3'h1;
					nxt_seen = 1'b1;
					nxt_addr = addr_ff + 16'h0001;
					if (is_read) begin
						nxt_rpar = rpar_ff ^ (^tx_ff);
					end
					if (!mem_ready) begin
						nxt_err = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			phase_ff <= SSSC_PH_CMD;
			cmd_ff <= SSSC_RST_CMD;
			addr_ff <= 16'h0000;
			tx_ff <= SSSC_RST_STAT;
			dcnt_ff <= 3'h0;
			seen_ff <= 1'b0;
			wpar_ff <= 1'b0;
			rpar_ff <= 1'b0;
			err_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			rd_go_ff <= 1'b0;
			stat_ff <= SSSC_RST_STAT;
			cmd_cap_ff <= SSSC_RST_CMD;
		end else begin
			phase_ff <= nxt_phase;
			cmd_ff <= nxt_cmd;
			addr_ff <= nxt_addr;
			tx_ff <= nxt_tx;
			dcnt_ff <= nxt_dcnt;
			seen_ff <= nxt_seen;
			wpar_ff <= nxt_wpar;
			rpar_ff <= nxt_rpar;
			err_ff <= nxt_err;
			rd_pend_ff <= nxt_rd_pend;
			rd_go_ff <= nxt_rd_go;
			stat_ff <= nxt_stat;
			cmd_cap_ff <= nxt_cmd_cap;
		end
	end

	// mpu register port; read data is registered, unmapped reads give zero
	always_comb begin
		nxt_en = en_ff;
		nxt_safe = safe_ff;
		nxt_rdata = mpu_rdata_q();
		if (mpu_wr && !mpu_sfr_sel && mpu_addr == SSSC_ADDR_CTRL) begin
			nxt_en = mpu_wdata[SSSC_BIT_EN];
			nxt_safe = mpu_wdata[SSSC_BIT_SAFE];
		end
	end

	function automatic logic [7:0] mpu_rdata_q();
		logic [7:0] v;
		v = 8'h00;
		if (mpu_rd) begin
			if (mpu_sfr_sel) begin
				if (mpu_addr[7:0] == SSSC_SFR_CMD) begin
					v = cmd_cap_ff;
				end
			end else if (mpu_addr == SSSC_ADDR_STAT) begin
				v = stat_ff;
			end else if (mpu_addr == SSSC_ADDR_CTRL) begin
				v[SSSC_BIT_EN] = en_ff;
				v[SSSC_BIT_SAFE] = safe_ff;
			end
		end
		return v;
	endfunction : mpu_rdata_q

	always_ff @(posedge clock or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			en_ff <= SSSC_RST_EN;
			safe_ff <= SSSC_RST_SAFE;
			rdata_ff <= 8'h00;
		end else begin
			en_ff <= nxt_en;
			safe_ff <= nxt_safe;
			rdata_ff <= nxt_rdata;
		end
	end
	assign mpu_rdata = rdata_ff;
endmodule : sssc_top

// File: verif/sssc_top_properties.sv
`timescale 1ns/10ps
// watches the top ports; tracks the control bits from mpu writes
module sssc_top_properties import sssc_pkg::*; #(
	parameter logic [15:0] SAFE_BASE = 16'h0000
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic csn_pin,
	input wire logic [3:0] segment_pin_assign,
	input wire logic spi_pins_active,
	input wire logic miso_oe,
	input wire logic mpu_sfr_sel,
	input wire logic [15:0] mpu_addr,
	input wire logic mpu_rd,
	input wire logic mpu_wr,
	input wire logic [7:0] mpu_wdata,
	input wire logic [7:0] mpu_rdata,
	input wire logic [15:0] mem_addr,
	input wire logic mem_flash,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic flash_read_lock
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	logic en_ff, safe_ff, nxt_en, nxt_safe, ctrl_wr, stat_rd;
	assign ctrl_wr = mpu_wr && !mpu_sfr_sel && mpu_addr == SSSC_ADDR_CTRL;
	assign stat_rd = mpu_rd && !mpu_sfr_sel && mpu_addr == SSSC_ADDR_STAT;
	// shadow of the control byte
	always_comb begin
		nxt_en = ctrl_wr ? mpu_wdata[SSSC_BIT_EN] : en_ff;
		nxt_safe = ctrl_wr ? mpu_wdata[SSSC_BIT_SAFE] : safe_ff;
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			en_ff <= SSSC_RST_EN;
			safe_ff <= SSSC_RST_SAFE;
		end else begin
			en_ff <= nxt_en;
			safe_ff <= nxt_safe;
		end
	end
	a_route_pins: assert property (spi_pins_active == (en_ff && segment_pin_assign == 4'h0))
		else $error("pin routing wrong");
	a_oe_routed: assert property (miso_oe |-> spi_pins_active)
		else $error("miso driven on unrouted pins");
	a_oe_idle: assert property (csn_pin [*6] |-> !miso_oe)
		else $error("miso driven outside frame");
	a_safe_window: assert property (safe_ff && mem_wr |->
		!mem_flash && 16'(mem_addr - SAFE_BASE) < 16'h0010)
		else $error("write outside safe window");
	a_ctrl_read: assert property (mpu_rd && !mpu_sfr_sel && mpu_addr == SSSC_ADDR_CTRL
		|=> mpu_rdata == {3'h0, $past(en_ff), $past(safe_ff), 3'h0})
		else $error("control readback wrong");
	a_rdata_idle: assert property (!mpu_rd |=> mpu_rdata == 8'h00)
		else $error("read data without read");
	a_lock_read: assert property (flash_read_lock && mem_rd |-> !mem_flash)
		else $error("flash read while locked");
	a_flash_pair: assert property (stat_rd |=>
		!mpu_rdata[SSSC_ST_FLASH_RDY] || mpu_rdata[SSSC_ST_FLASH]) else $error("ready without mode");
	a_stat_hold: assert property (csn_pin [*5] ##0 stat_rd ##2 (stat_rd && csn_pin)
		|=> mpu_rdata == $past(mpu_rdata, 2)) else $error("status moved between frames");
endmodule : sssc_top_properties
bind sssc_top sssc_top_properties #(.SAFE_BASE(SAFE_BASE)) u_chk (.*);

// File: verif/sssc_spi_host.sv
`timescale 1ns/10ps
// mode 0 bus master, half period of eight clocks
module sssc_spi_host (
	input wire logic clock,
	output logic sck_pin,
	output logic csn_pin,
	output logic mosi_pin,
	input wire logic miso_out,
	input wire logic miso_oe
);
	initial begin
		sck_pin = 1'b0;
		csn_pin = 1'b1;
		mosi_pin = 1'b0;
	end
	task automatic hc(input int n);
		repeat (n) @(negedge clock);
	endtask : hc
	task automatic start;
		csn_pin = 1'b0;
		hc(8);
	endtask : start
	// an undriven miso reads as unknown, so a dropped enable cannot pass
	task automatic xb(input logic [7:0] t, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			mosi_pin = t[i];
			hc(8);
			sck_pin = 1'b1;
			r[i] = miso_oe ? miso_out : 1'bx;
			hc(8);
			sck_pin = 1'b0;
		end
	endtask : xb
	// released data line flips so a stale level is never mistaken for data
	task automatic stop;
		hc(4);
		csn_pin = 1'b1;
		mosi_pin = ~mosi_pin;
		hc(12);
	endtask : stop
endmodule : sssc_spi_host

// File: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top import sssc_pkg::*;;
	logic clock = 1'b0, resetn = 1'b0, test_pin = 1'b0, mpu_sfr_sel = 1'b0, mpu_rd = 1'b0;
	logic mpu_wr = 1'b0, mem_ready = 1'b1, flash_read_lock = 1'b0, flash_mode = 1'b1;
	logic flash_ready = 1'b1, miso_out, miso_oe, spi_pins_active, mem_flash, mem_rd, mem_wr;
	logic [3:0] segment_pin_assign = 4'h0;
	logic [15:0] mpu_addr = 16'h0000, mem_addr, wa;
	logic [7:0] mpu_wdata = 8'h00, mpu_rdata, mem_wdata, mem_rdata, prev = 8'h00, rd0, wd;
	wire logic sck_pin, csn_pin, mosi_pin;
	int miscompares = 0, num_checks = 0, nwr = 0, nrd = 0;
	// reset values: sfr select, address, expected data
	logic [24:0] rows [5] = '{{1'b1, 16'h00fd, 8'h00}, {1'b0, 16'h2708, 8'h00},
		{1'b0, 16'h270c, 8'h10}, {1'b0, 16'h2709, 8'h00}, {1'b1, 16'h00fe, 8'h00}};
	sssc_top dut (.*);
	sssc_spi_host h (.*);
	always #20 clock = ~clock;
	// memory latches the address at the read strobe and answers a cycle later
	always @(posedge clock) begin
		if (mem_wr) begin
			nwr <= nwr + 1;
			wa <= mem_addr;
			wd <= mem_wdata;
		end
		if (mem_rd) begin
			nrd <= nrd + 1;
			mem_rdata <= mem_addr[7:0] ^ 8'h3c;
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task mrd(input logic s, input logic [15:0] a, output logic [7:0] d);
		@(negedge clock);
		mpu_sfr_sel = s;
		mpu_addr = a;
		mpu_rd = 1'b1;
		@(negedge clock);
		d = mpu_rdata;
		mpu_rd = 1'b0;
	endtask : mrd
	task mwr(input logic [7:0] v);
		@(negedge clock);
		mpu_sfr_sel = 1'b0;
		mpu_addr = SSSC_ADDR_CTRL;
		mpu_wdata = v;
		mpu_wr = 1'b1;
		@(negedge clock);
		mpu_wr = 1'b0;
	endtask : mwr
	// one frame, then two status reads; data byte a5 has even parity
	task fr(input logic [7:0] c, input logic [15:0] a, input int n, input logic [7:0] e);
		logic [7:0] r;
		h.start();
		h.xb(c, r);
		check(r, prev);
		h.xb(a[15:8], r);
		h.xb(a[7:0], r);
		for (int i = 0; i < n; i++) begin
			h.xb(8'ha5, r);
			if (i == 0) rd0 = r;
		end
		h.stop();
		for (int k = 0; k < 2; k++) begin
			mrd(1'b0, SSSC_ADDR_STAT, r);
			check(r, e);
		end
		prev = e;
	endtask : fr
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (100000) @(posedge clock);
		miscompares++;
		print_verdict;
	end
	initial begin
		logic [7:0] r;
		int w;
		repeat (12) @(negedge clock);
		resetn = 1'b1;
		repeat (4) @(negedge clock);
		check({7'h0, spi_pins_active}, 8'h01);
		foreach (rows[i]) begin
			mrd(rows[i][24], rows[i][23:8], r);
			check(r, rows[i][7:0]);
		end
		fr(8'h01, 16'h0005, 1, 8'h24);
		check(wa[7:0], 8'h05);
		check(wd, 8'ha5);
		mrd(1'b1, 16'h00fd, r);
		check(r, 8'h01);
		fr(8'h80, 16'h0010, 2, 8'h48);
		check(rd0, 8'h2c);
		fr(8'h01, 16'h0000, 0, 8'h3c);
		mwr(8'h18);
		mrd(1'b0, SSSC_ADDR_CTRL, r);
		check(r, 8'h18);
		w = nwr;
		fr(8'h01, 16'h0020, 1, 8'h04);
		fr(8'h41, 16'h0003, 1, 8'h04);
		check(8'(nwr - w), 8'h00);
		fr(8'h01, 16'h0003, 1, 8'h24);
		check(8'(nwr - w), 8'h01);
		mwr(8'h10);
		mem_ready = 1'b0;
		fr(8'h80, 16'h0010, 1, 8'h84);
		check(rd0, 8'h00);
		mem_ready = 1'b1;
		flash_read_lock = 1'b1;
		w = nrd;
		fr(8'hc0, 16'h0010, 1, 8'h24);
		check(rd0, 8'h00);
		check(8'(nrd - w), 8'h00);
		w = nrd;
		fr(8'h80, 16'h0010, 1, 8'h44);
		check(rd0, 8'h2c);
		check(8'(nrd - w), 8'h02);
		flash_read_lock = 1'b0;
		test_pin = 1'b1;
		fr(8'h01, 16'h0000, 0, 8'h3f);
		test_pin = 1'b0;
		fr(8'h01, 16'h0000, 0, 8'h3c);
		mwr(8'h00);
		check({7'h0, spi_pins_active}, 8'h00);
		mwr(8'h10);
		segment_pin_assign = 4'h8;
		@(negedge clock);
		check({7'h0, spi_pins_active}, 8'h00);
		segment_pin_assign = 4'h0;
		// second reset in mid-run must restore control, status and capture
		mwr(8'h08);
		@(negedge clock);
		resetn = 1'b0;
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		repeat (4) @(negedge clock);
		foreach (rows[i]) begin
			mrd(rows[i][24], rows[i][23:8], r);
			check(r, rows[i][7:0]);
		end
		prev = 8'h00;
		fr(8'h01, 16'h0000, 0, 8'h3c);
		print_verdict;
	end
endmodule : tb_top
